// >>> core/bsel_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the source picker
// Assumes: included by bare name
// Notes:   definitions only
`ifndef BSEL_CONSTS_SVH
`define BSEL_CONSTS_SVH

// register offsets
`define BSEL_ADDR_CTRL    8'h00
`define BSEL_ADDR_FREQ    8'h04
`define BSEL_ADDR_MODIDX  8'h08
`define BSEL_ADDR_WEIGHT  8'h0C
`define BSEL_ADDR_THRESH  8'h10
`define BSEL_ADDR_DELAY   8'h14
`define BSEL_ADDR_STATUS  8'h18
`define BSEL_ADDR_TUNE    8'h1C
`define BSEL_ADDR_MODOUT  8'h20

// control and status field positions
`define BSEL_CTRL_PICK    0
`define BSEL_CTRL_DCANT   1
`define BSEL_CTRL_CMBON   2
`define BSEL_CTRL_RETAIN  3
`define BSEL_CTRL_HOLD    4
`define BSEL_STAT_REJECT  0

// reset values
`define BSEL_CTRL_RST     5'h05
`define BSEL_FREQ_RST     13'h0190
`define BSEL_IDX_RST      16'h02BC
`define BSEL_WEIGHT_RST   16'h8080
`define BSEL_THRESH_RST   8'h04
`define BSEL_DELAY_RST    12'h000

// frequency plan in MHz and index limits in thousandths
`define BSEL_LO_MHZ       13'h15AE
`define BSEL_C_LO         13'h1130
`define BSEL_C_HI         13'h141E
`define BSEL_P_LO         13'h0190
`define BSEL_P_HI         13'h047E
`define BSEL_IDX_MIN      16'h015E
`define BSEL_IDX_MAX      16'h1F40

// timing
`define BSEL_CLK_KHZ      40000
`define BSEL_SNAP_MS      100
`define BSEL_FRAME_BITS   64
`define BSEL_DQE_SYNC     16'hA5C3

`endif

// >>> core/bsel_pkg.sv
// Purpose: types shared by the source picker
// Assumes: nothing
// Notes:   constants live in bsel_consts.svh
package bsel_pkg;
    typedef enum logic [1:0] {
        SRC_DISABLED = 2'h0,
        SRC_BAD      = 2'h1,
        SRC_GOOD     = 2'h2,
        SRC_BEST     = 2'h3
    } bsel_state_t;

    typedef logic [1:0] bsel_src_t;
endpackage

// >>> core/bsel_source_picker.sv
// Purpose: per-bit best source picker, tuning decision and modulation index control
// Assumes: demod strobes and data on clk_sys; cmbPresent is an async pin
// Notes:   sources are indexed 0 = channel 1, 1 = combiner, 2 = channel 2
`include "bsel_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module bsel_source_picker #(
    parameter int FRAME_BITS  = `BSEL_FRAME_BITS,
    parameter int SNAP_CYCLES = `BSEL_SNAP_MS * `BSEL_CLK_KHZ
) (
    // clock and reset
    input  wire  logic        clk_sys,
    input  wire  logic        rst_n,
    // register port
    input  wire  logic [7:0]  regAddr,
    input  wire  logic [31:0] regWdata,
    input  wire  logic        regWr,
    input  wire  logic        regRd,
    output logic       [31:0] regRdata,
    // demodulator side
    input  wire  logic        bitStb,
    input  wire  logic        ch1Bit,
    input  wire  logic        cmbBit,
    input  wire  logic        ch2Bit,
    input  wire  logic [7:0]  ch1Qual,
    input  wire  logic [7:0]  cmbQual,
    input  wire  logic [7:0]  ch2Qual,
    input  wire  logic [11:0] ch1Sample,
    input  wire  logic [11:0] ch2Sample,
    input  wire  logic [15:0] idxEstimate,
    input  wire  logic        nvIdxLoad,
    input  wire  logic [15:0] nvIdx,
    input  wire  logic        cmbPresent,
    // data output
    output logic       [11:0] cmbSample_q,
    output logic              dataOut_q,
    output logic              dataStb_q,
    output logic              dqeStart_q,
    output logic       [31:0] dqeHeader_q,
    // status
    output logic       [7:0]  selQual_q,
    output logic       [5:0]  srcState_q,
    output logic              statusValid_q,
    // tuning and index
    output logic       [12:0] tuneFreq_q,
    output logic              reinvert_q,
    output logic       [15:0] modIdx_q,
    output logic              modHold_q,
    output logic              persistIdx_q
);
    import bsel_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    if (FRAME_BITS < 2 || FRAME_BITS > 255) begin : g_badFrame
        $error("FRAME_BITS must be 2..255");
    end
    if (SNAP_CYCLES < 2) begin : g_badSnap
        $error("SNAP_CYCLES must be at least 2");
    end

    function automatic bsel_src_t pickBest(input bsel_src_t cur, input logic [2:0] elig, input logic [23:0] q);
        bsel_src_t b;
        b = cur;
        for (int i = 0; i < 3; i++) begin
            if (elig[i] && q[8*i +: 8] > q[8*b +: 8]) begin
                b = bsel_src_t'(i);
            end
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [4:0]  ctrl_q;
    logic [12:0] freq_q;
    logic [15:0] heldIdx_q;
    logic [15:0] weight_q;
    logic [7:0]  thresh_q;
    logic [11:0] delay_q;
    logic        reject_q;
    logic        presMeta_q;
    logic        presSync_q;

    wire wrCtrl   = regWr && regAddr == `BSEL_ADDR_CTRL;
    wire wrIdx    = regWr && regAddr == `BSEL_ADDR_MODIDX;
    wire wrStat   = regWr && regAddr == `BSEL_ADDR_STATUS;
    wire idxOk    = regWdata[15:0] >= `BSEL_IDX_MIN && regWdata[15:0] <= `BSEL_IDX_MAX;
    wire nvOk     = nvIdx >= `BSEL_IDX_MIN && nvIdx <= `BSEL_IDX_MAX;
    wire nvTake   = nvIdxLoad && ctrl_q[`BSEL_CTRL_RETAIN] && nvOk;
    wire idxTake  = wrIdx && idxOk;
    wire goTrack  = wrCtrl && !regWdata[`BSEL_CTRL_HOLD];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= `BSEL_CTRL_RST;
            freq_q   <= `BSEL_FREQ_RST;
            weight_q <= `BSEL_WEIGHT_RST;
            thresh_q <= `BSEL_THRESH_RST;
            delay_q  <= `BSEL_DELAY_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= regWdata[4:0];
            end else if (idxTake || nvTake) begin
                ctrl_q[`BSEL_CTRL_HOLD] <= 1'b1;
            end
            if (regWr && regAddr == `BSEL_ADDR_FREQ) begin
                freq_q <= regWdata[12:0];
            end
            if (regWr && regAddr == `BSEL_ADDR_WEIGHT) begin
                weight_q <= regWdata[15:0];
            end
            if (regWr && regAddr == `BSEL_ADDR_THRESH) begin
                thresh_q <= regWdata[7:0];
            end
            if (regWr && regAddr == `BSEL_ADDR_DELAY) begin
                delay_q <= regWdata[11:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reject_q <= 1'b0;
        end else if (wrIdx && !idxOk) begin
            reject_q <= 1'b1;
        end else if (wrStat && regWdata[`BSEL_STAT_REJECT]) begin
            reject_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            heldIdx_q <= `BSEL_IDX_RST;
        end else if (idxTake) begin
            heldIdx_q <= regWdata[15:0];
        end else if (nvTake) begin
            heldIdx_q <= nvIdx;
        end else if (goTrack) begin
            heldIdx_q <= `BSEL_IDX_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modIdx_q     <= `BSEL_IDX_RST;
            modHold_q    <= 1'b0;
            persistIdx_q <= 1'b0;
        end else begin
            modIdx_q     <= ctrl_q[`BSEL_CTRL_HOLD] ? heldIdx_q : idxEstimate;
            modHold_q    <= ctrl_q[`BSEL_CTRL_HOLD];
            persistIdx_q <= ctrl_q[`BSEL_CTRL_HOLD] && ctrl_q[`BSEL_CTRL_RETAIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // tuning decision
    wire isCBand = freq_q >= `BSEL_C_LO && freq_q <= `BSEL_C_HI;
    wire isPBand = freq_q >= `BSEL_P_LO && freq_q <= `BSEL_P_HI;
    wire dcAnt   = ctrl_q[`BSEL_CTRL_DCANT];
    wire [12:0] pEquiv = `BSEL_LO_MHZ - freq_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tuneFreq_q <= `BSEL_FREQ_RST;
            reinvert_q <= 1'b0;
        end else if (isCBand && dcAnt) begin
            tuneFreq_q <= pEquiv;
            reinvert_q <= 1'b1;
        end else begin
            tuneFreq_q <= freq_q;
            reinvert_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // combiner sample
    wire signed [20:0] prod1 = $signed(ch1Sample) * $signed({1'b0, weight_q[7:0]});
    wire signed [20:0] prod2 = $signed(ch2Sample) * $signed({1'b0, weight_q[15:8]});
    wire signed [21:0] wsum  = {prod1[20], prod1} + {prod2[20], prod2};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmbSample_q <= 12'h000;
        end else begin
            cmbSample_q <= wsum[19:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // delay matching and selection
    wire [2:0]  srcBit = {ch2Bit, cmbBit, ch1Bit};
    wire [23:0] qAll   = {ch2Qual, cmbQual, ch1Qual};
    logic [2:0] dlyBit;
    logic       stbD1_q;
    logic       cmbD1_q;
    logic       enApplied_q;
    bsel_src_t  best_q;
    logic [2:0] corrOk_q;

    for (genvar g = 0; g < 3; g++) begin : g_dly
        logic [15:0] line_q;
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                line_q <= 16'h0000;
            end else if (bitStb) begin
                line_q <= {line_q[14:0], srcBit[g]};
            end
        end
        assign dlyBit[g] = line_q[delay_q[4*g +: 4]];
    end

    wire [2:0]  elig        = corrOk_q | (3'b001 << best_q);
    wire bsel_src_t bestNext = pickBest(best_q, elig, qAll);
    wire        betterExist = pickBest(best_q, elig, qAll) != best_q;
    wire        selBit      = dlyBit[bestNext];
    wire [7:0]  liveQual    = qAll[8*bestNext +: 8];

    logic [7:0]  frameCnt_q;
    logic [FRAME_BITS-1:0] frameLine_q;
    wire         frameEnd   = stbD1_q && frameCnt_q == 8'(FRAME_BITS - 1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stbD1_q     <= 1'b0;
            cmbD1_q     <= 1'b0;
            enApplied_q <= 1'b0;
        end else begin
            stbD1_q <= bitStb;
            if (bitStb) begin
                cmbD1_q     <= cmbBit;
                enApplied_q <= ctrl_q[`BSEL_CTRL_PICK];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            best_q      <= 2'h1;
            frameCnt_q  <= 8'h00;
            frameLine_q <= '0;
        end else if (stbD1_q) begin
            best_q      <= bestNext;
            frameCnt_q  <= frameEnd ? 8'h00 : frameCnt_q + 8'h01;
            frameLine_q <= {frameLine_q[FRAME_BITS-2:0], selBit};
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_corr
        logic [7:0] miss_q;
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                miss_q      <= 8'h00;
                corrOk_q[g] <= 1'b1;
            end else if (frameEnd) begin
                miss_q      <= 8'h00;
                corrOk_q[g] <= (miss_q <= thresh_q);
            end else if (stbD1_q && dlyBit[g] != selBit && miss_q != 8'hFF) begin
                miss_q <= miss_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dataOut_q <= 1'b0;
            dataStb_q <= 1'b0;
        end else begin
            dataStb_q <= stbD1_q;
            if (stbD1_q) begin
                dataOut_q <= enApplied_q ? frameLine_q[FRAME_BITS-1] : cmbD1_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dqeStart_q  <= 1'b0;
            dqeHeader_q <= 32'h0000_0000;
        end else begin
            dqeStart_q <= frameEnd && enApplied_q;
            if (frameEnd) begin
                dqeHeader_q <= {`BSEL_DQE_SYNC, 8'h00, liveQual};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // status snapshot
    logic [31:0] snapCnt_q;
    wire         snapTick = snapCnt_q == 32'(SNAP_CYCLES - 1);
    wire         statGate = presSync_q && ctrl_q[`BSEL_CTRL_CMBON];
    logic [5:0]  liveState;

    for (genvar g = 0; g < 3; g++) begin : g_state
        assign liveState[2*g +: 2] = !enApplied_q ? SRC_DISABLED :
                                     (bsel_src_t'(g) == best_q) ? SRC_BEST :
                                     corrOk_q[g] ? SRC_GOOD : SRC_BAD;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presMeta_q <= 1'b0;
            presSync_q <= 1'b0;
            snapCnt_q  <= 32'h0000_0000;
        end else begin
            presMeta_q <= cmbPresent;
            presSync_q <= presMeta_q;
            snapCnt_q  <= snapTick ? 32'h0000_0000 : snapCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            selQual_q     <= 8'h00;
            srcState_q    <= 6'h00;
            statusValid_q <= 1'b0;
        end else begin
            statusValid_q <= statGate;
            if (!statGate) begin
                selQual_q  <= 8'h00;
                srcState_q <= 6'h00;
            end else if (snapTick) begin
                selQual_q  <= enApplied_q ? qAll[8*best_q +: 8] : 8'h00;
                srcState_q <= liveState;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // read port
    logic [31:0] rdMux;
    always_comb begin
        case (regAddr)
            `BSEL_ADDR_CTRL:   rdMux = {27'h000_0000, ctrl_q};
            `BSEL_ADDR_FREQ:   rdMux = {19'h0_0000, freq_q};
            `BSEL_ADDR_MODIDX: rdMux = {16'h0000, heldIdx_q};
            `BSEL_ADDR_WEIGHT: rdMux = {16'h0000, weight_q};
            `BSEL_ADDR_THRESH: rdMux = {24'h00_0000, thresh_q};
            `BSEL_ADDR_DELAY:  rdMux = {20'h0_0000, delay_q};
            `BSEL_ADDR_STATUS: rdMux = {8'h00, statusValid_q, srcState_q, selQual_q, 8'h00, reject_q};
            `BSEL_ADDR_TUNE:   rdMux = {18'h0_0000, reinvert_q, tuneFreq_q};
            `BSEL_ADDR_MODOUT: rdMux = {15'h0000, modHold_q, modIdx_q};
            default:           rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRd ? rdMux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_tune_cdown: assert property (
        isCBand && dcAnt |=> reinvert_q && tuneFreq_q == `BSEL_LO_MHZ - $past(freq_q))
        else $error("c band with antenna flag not tuned to lo minus command");
    chk_tune_cdirect: assert property (
        isCBand && !dcAnt |=> !reinvert_q && tuneFreq_q == $past(freq_q))
        else $error("c band without flag not tuned directly");
    chk_tune_pband: assert property (
        isPBand ##1 isPBand |-> !reinvert_q && tuneFreq_q == $past(freq_q))
        else $error("p band tuning wrong or inversion on");
    chk_idx_reject: assert property (
        wrIdx && !idxOk |=> reject_q && $stable(heldIdx_q))
        else $error("out of range index accepted");
    chk_idx_hold: assert property (
        idxTake |=> ##1 modHold_q && modIdx_q == $past(regWdata[15:0], 2))
        else $error("index write did not hold new value");
    chk_idx_track: assert property (
        goTrack |=> ##1 !modHold_q && modIdx_q == $past(idxEstimate))
        else $error("tracking does not follow estimate");
    chk_out_bypass: assert property (
        stbD1_q && !enApplied_q |=> dataStb_q && dataOut_q == $past(cmbD1_q))
        else $error("bypass output not from combiner");
    chk_pick_stick: assert property (
        stbD1_q && !betterExist |=> $stable(best_q))
        else $error("choice changed without better source");
    chk_status_gate: assert property (
        !statGate |=> !statusValid_q && srcState_q == 6'h00)
        else $error("status shown without combiner");

    cov_pick_ch2:   cover property (stbD1_q && enApplied_q && bestNext == 2'h2);
    cov_bad_source: cover property (frameEnd && enApplied_q ##1 corrOk_q != 3'b111);
    cov_dqe_frame:  cover property (dqeStart_q);
endmodule

`default_nettype wire

// >>> tb/bsel_demod_model.sv
// Purpose: demodulator side of the source picker, one bit every four clocks
// Assumes: run and cmbFlip come from the bench on clk_sys
// Notes:   channels carry one pattern that flips every 32 bits, the combiner the same or its inverse while cmbFlip is set
`timescale 1ns/1ps
`default_nettype none
module bsel_demod_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // bench control
    input  wire logic        run,
    input  wire logic        cmbFlip,
    // demodulator outputs
    output logic             bitStb,
    output logic             ch1Bit,
    output logic             cmbBit,
    output logic             ch2Bit,
    output logic      [11:0] ch1Sample,
    output logic      [11:0] ch2Sample,
    output logic      [15:0] idxEstimate
);
    logic [1:0] phase;
    logic [9:0] bitCnt;
    logic       fire;
    ////////////////////////////////////////////////////////////////////////
    assign fire        = run && phase == 2'h3;
    assign ch1Sample   = 12'h100;
    assign ch2Sample   = 12'h100;
    assign idxEstimate = 16'h0320;
    ////////////////////////////////////////////////////////////////////////
    // sources delay matched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase  <= 2'h0;
            bitCnt <= 10'h000;
            bitStb <= 1'b0;
            ch1Bit <= 1'b0;
            cmbBit <= 1'b0;
            ch2Bit <= 1'b0;
        end else begin
            phase  <= run ? phase + 2'h1 : 2'h0;
            bitStb <= fire;
            if (fire) begin
                bitCnt <= bitCnt + 10'h001;
                ch1Bit <= bitCnt[5];
                cmbBit <= bitCnt[5] ^ cmbFlip;
                ch2Bit <= bitCnt[5];
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/bsel_source_picker_tb.sv
// Purpose: self-checking bench of the source picker
// Assumes: 40 MHz clock, short frame and snapshot counts
// Notes:   expected values worked out here, never read back from the design
`include "bsel_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bsel_source_picker_tb;
    import bsel_pkg::*;
    localparam int FRB  = 8;
    localparam int SNAP = 50;
    logic        clk_sys, rst_n, regWr, regRd, cmbPresent, run, cmbFlip, lastCmb;
    logic        bitStb, ch1Bit, cmbBit, ch2Bit, dataOut_q, dataStb_q, dqeStart_q;
    logic        statusValid_q, reinvert_q, modHold_q, persistIdx_q, nvIdxLoad;
    logic [7:0]  regAddr, ch1Qual, cmbQual, ch2Qual, selQual_q;
    logic [31:0] regWdata, regRdata, dqeHeader_q;
    logic [11:0] ch1Sample, ch2Sample, cmbSample_q;
    logic [15:0] idxEstimate, modIdx_q, nvIdx;
    logic [12:0] tuneFreq_q;
    logic [5:0]  srcState_q;
    int          miscompares, checksDone, sentN, cycles;
    ////////////////////////////////////////////////////////////////////////
    bsel_source_picker #(.FRAME_BITS(FRB), .SNAP_CYCLES(SNAP)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .bitStb(bitStb),
        .ch1Bit(ch1Bit), .cmbBit(cmbBit), .ch2Bit(ch2Bit), .ch1Qual(ch1Qual),
        .cmbQual(cmbQual), .ch2Qual(ch2Qual), .ch1Sample(ch1Sample), .ch2Sample(ch2Sample),
        .idxEstimate(idxEstimate), .nvIdxLoad(nvIdxLoad), .nvIdx(nvIdx), .cmbPresent(cmbPresent),
        .cmbSample_q(cmbSample_q), .dataOut_q(dataOut_q), .dataStb_q(dataStb_q),
        .dqeStart_q(dqeStart_q), .dqeHeader_q(dqeHeader_q), .selQual_q(selQual_q),
        .srcState_q(srcState_q), .statusValid_q(statusValid_q), .tuneFreq_q(tuneFreq_q),
        .reinvert_q(reinvert_q), .modIdx_q(modIdx_q), .modHold_q(modHold_q),
        .persistIdx_q(persistIdx_q));
    bsel_demod_model u_demod (
        .clk_sys(clk_sys), .rst_n(rst_n), .run(run), .cmbFlip(cmbFlip), .bitStb(bitStb),
        .ch1Bit(ch1Bit), .cmbBit(cmbBit), .ch2Bit(ch2Bit), .ch1Sample(ch1Sample),
        .ch2Sample(ch2Sample), .idxEstimate(idxEstimate));
    ////////////////////////////////////////////////////////////////////////
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (bitStb === 1'b1) begin
            sentN   <= sentN + 1;
            lastCmb <= cmbBit;
        end
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            printVerdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic waitStb();
        int k;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (dataStb_q !== 1'b1 && k < 12);
        check(dataStb_q, 1'b1);
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic testTune();
        logic [31:0] d;
        logic [4:0]  tc[4] = '{5'h07, 5'h07, 5'h05, 5'h07};
        logic [12:0] tf[4] = '{13'h1130, 13'h141E, 13'h1130, 13'h047E};
        logic [12:0] te[4] = '{13'h047E, 13'h0190, 13'h1130, 13'h047E};
        logic        ti[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        check(tuneFreq_q, 13'h0190);
        check(reinvert_q, 1'b0);
        rd(`BSEL_ADDR_THRESH, d);
        check(d, 32'h0000_0004);
        rd(8'h40, d);
        check(d, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(`BSEL_ADDR_CTRL, {27'h0, tc[k]});
            wr(`BSEL_ADDR_FREQ, {19'h0, tf[k]});
            tick(2);
            check(tuneFreq_q, te[k]);
            check(reinvert_q, ti[k]);
            rd(`BSEL_ADDR_TUNE, d);
            check(d, {18'h0, ti[k], te[k]});
        end
        $display("tuning test done");
    endtask
    task automatic testIndex();
        logic [31:0] d;
        wr(`BSEL_ADDR_MODIDX, 32'h0000_1F41);
        tick(2);
        check(modHold_q, 1'b0);
        check(modIdx_q, 16'h0320);
        rd(`BSEL_ADDR_STATUS, d);
        check(d[0], 1'b1);
        wr(`BSEL_ADDR_STATUS, 32'h0000_0001);
        wr(`BSEL_ADDR_MODIDX, 32'h0000_015E);
        tick(2);
        check(modIdx_q, 16'h015E);
        check(modHold_q, 1'b1);
        rd(`BSEL_ADDR_MODOUT, d);
        check(d, 32'h0001_015E);
        wr(`BSEL_ADDR_MODIDX, 32'h0000_015D);
        tick(2);
        check(modIdx_q, 16'h015E);
        wr(`BSEL_ADDR_CTRL, 32'h0000_001D);
        tick(2);
        check(persistIdx_q, 1'b1);
        nvIdx     <= 16'h0BB8;
        nvIdxLoad <= 1'b1;
        tick(1);
        nvIdxLoad <= 1'b0;
        tick(2);
        check(modIdx_q, 16'h0BB8);
        wr(`BSEL_ADDR_CTRL, 32'h0000_0005);
        tick(2);
        check(modHold_q, 1'b0);
        check(modIdx_q, 16'h0320);
        check(persistIdx_q, 1'b0);
        nvIdxLoad <= 1'b1;
        tick(1);
        nvIdxLoad <= 1'b0;
        tick(2);
        check(modHold_q, 1'b0);
        check(modIdx_q, 16'h0320);
        $display("index test done");
    endtask
    task automatic testBypass();
        wr(`BSEL_ADDR_CTRL, 32'h0000_0004);
        cmbFlip <= 1'b1;
        run     <= 1'b1;
        repeat (20) begin
            waitStb();
            check(dataOut_q, lastCmb);
        end
        check(cmbSample_q, 12'h100);
        $display("bypass test done");
    endtask
    task automatic testPicker();
        int i;
        cmbFlip <= 1'b0;
        ch1Qual <= 8'h64;
        cmbQual <= 8'h96;
        ch2Qual <= 8'hC8;
        wr(`BSEL_ADDR_CTRL, 32'h0000_0005);
        repeat (100) begin
            waitStb();
            i = sentN - FRB - 1;
            if (i > 40)
                check(dataOut_q, i[5]);
        end
        tick(120);
        check(srcState_q, {SRC_BEST, SRC_GOOD, SRC_GOOD});
        check(selQual_q, 8'hC8);
        check(statusValid_q, 1'b1);
        for (int k = 0; k < 80 && dqeStart_q !== 1'b1; k++)
            tick(1);
        check(dqeStart_q, 1'b1);
        check(dqeHeader_q, {`BSEL_DQE_SYNC, 8'h00, 8'hC8});
        ch1Qual <= 8'hC8;
        tick(150);
        check(srcState_q, {SRC_BEST, SRC_GOOD, SRC_GOOD});
        cmbFlip <= 1'b1;
        tick(150);
        check(srcState_q, {SRC_BEST, SRC_BAD, SRC_GOOD});
        check(selQual_q, 8'hC8);
        $display("picker test done");
    endtask
    task automatic testGate();
        wr(`BSEL_ADDR_CTRL, 32'h0000_0004);
        tick(150);
        check(srcState_q, 6'h00);
        check(selQual_q, 8'h00);
        wr(`BSEL_ADDR_CTRL, 32'h0000_0000);
        tick(3);
        check(statusValid_q, 1'b0);
        wr(`BSEL_ADDR_CTRL, 32'h0000_0005);
        cmbPresent <= 1'b0;
        tick(6);
        check(statusValid_q, 1'b0);
        cmbPresent <= 1'b1;
        tick(6);
        check(statusValid_q, 1'b1);
        $display("status gate test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys    = 1'b0;
        rst_n      = 1'b0;
        regAddr    = 8'h00;
        regWdata   = 32'h0000_0000;
        regWr      = 1'b0;
        regRd      = 1'b0;
        cmbPresent = 1'b1;
        run        = 1'b0;
        cmbFlip    = 1'b0;
        nvIdxLoad  = 1'b0;
        nvIdx      = 16'h0000;
        ch1Qual    = 8'h00;
        cmbQual    = 8'h00;
        ch2Qual    = 8'h00;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(1);
        testTune();
        testIndex();
        testBypass();
        testPicker();
        testGate();
        printVerdict();
    end
endmodule
`default_nettype wire
